// ==== epv_pkg.sv ====
// package for exception priority and vectoring logic
package epv_pkg;
   // vector addresses
   localparam logic [15:0] VEC_RESET = 16'hfffe;
   localparam logic [15:0] VEC_CLKMON = 16'hfffc;
   localparam logic [15:0] VEC_WDOG = 16'hfffa;
   localparam logic [15:0] VEC_TRAP = 16'hfff8;
   localparam logic [15:0] VEC_SWTRAP = 16'hfff6;
   localparam logic [15:0] VEC_NMI = 16'hfff4;
   localparam logic [15:0] VEC_EXT = 16'hfff2;
   localparam logic [15:0] VEC_BASE = 16'hff80;
   localparam logic [7:0] PRIO_EXT = 8'hf2;
   localparam logic [7:0] PRIO_RESET = 8'hf2;
   localparam logic [7:0] PRIO_LOW_MIN = 8'h80;
   // maskable source count: index 0 = vector F2, index k = F2 - 2k
   localparam int NSRC = 57;
   localparam logic [NSRC-1:0] IMPL_MASK = {{(NSRC-25){1'b0}}, 25'h1ffffff};
   // register map, byte offsets on wishbone
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_PRIO = 4'h4;
   localparam logic [3:0] OFF_STAT = 4'h8;
   localparam int CTRL_EDGE_BIT = 7;
   localparam int CTRL_EN_BIT = 6;
   localparam logic [7:0] CTRL_RESET = 8'h40;
   // state of the arbiter
   typedef struct packed {
      logic [7:0] prio;
      logic edge_sel;
      logic ext_en;
      logic ext_s1;
      logic ext_s2;
      logic ext_prev;
      logic edge_latch;
      logic nmi_s1;
      logic nmi_s2;
      logic [15:0] vector;
      logic valid;
      logic ack;
      logic [31:0] rdata;
   } epv_state_t;
   // wishbone request bundle
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } epv_wb_req_t;
endpackage

// ==== epv_arbiter.sv ====
// exception arbiter with vector output and wishbone control registers
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
// How it works
// R1 - every exception yields a 16-bit vector in the top 128 bytes
// R2 - six top slots are resets and non-maskable, lower slots maskable
// R3 - non-maskable order: reset, clock monitor, watchdog, trap, soft trap, line
// R4 - non-maskable external line honoured only while X bit is zero
// R5 - maskable requests only while I bit clear; I resets set in core
// R6 - default maskable order; one source may be promoted to top
// R7 - promoted source still gated by I and local enable; vector unchanged
// R8 - priority select written only while I bit set
// R9 - non-maskable line level sensitive; external request may be level
// R10 - vanished level request before service takes the trap vector
// R11 - edge mode latches falling edge, cleared when serviced
// R12 - peripheral requests held in flags until cleared by their owner
// R13 - fixed vectors FFFE, FFFC, FFFA, FFF8, FFF6, FFF4
// R14 - maskable priority descends with vector; code is vector low byte
// R15 - timer channels FFEE..FFE0, timer overflow FFDE
// R16 - accumulator overflow FFDC, accumulator edge FFDA
// R17 - SPI FFD8, serial FFD6 and FFD4, converters share FFD2
// R18 - CAN wake FFD0, key wake FFCE, modulus FFCC
// R19 - accum B FFCA, CAN errors FFC8, CAN rx FFC6, CAN tx FFC4
// R20 - clock generator FFC2; FF80..FFC1 reserved and I-masked
// R21 - software fills every maskable vector slot
// R22 - unimplemented or above-F2 code makes external line top
// R23 - priority select resets to F2
// R24 - edge select chooses low level or falling edge
// R25 - enable clear disconnects external request pin
// R26 - each cycle highest pending unmasked request drives the vector
module epv_arbiter #(
   parameter int NPERIPH = 24
) (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire epv_pkg::epv_wb_req_t wb_req_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic por_req_in,
   input wire logic clkmon_req_in,
   input wire logic wdog_req_in,
   input wire logic trap_req_in,
   input wire logic swtrap_req_in,
   input wire logic nonmaskable_ext_line_n_in,
   input wire logic ext_req_n_in,
   input wire logic x_mask_in,
   input wire logic i_mask_in,
   input wire logic [NPERIPH-1:0] periph_flag_in,
   input wire logic [NPERIPH-1:0] periph_en_in,
   input wire logic service_in,
   output logic [15:0] vector_out,
   output logic vector_valid_out
);
   import epv_pkg::*;

   // elaboration check: the vector map holds exactly 24 peripheral slots
   if (NPERIPH != 24) begin : g_bad_nperiph
      $error("epv_arbiter serves exactly 24 peripheral vectors");
   end

   epv_state_t st_ff;
   epv_state_t nxt_st;
   logic [NSRC-1:0] req;
   logic [NSRC-1:0] code_ok;
   logic ext_level;
   logic ext_req;
   logic wb_hit;

   // vector address of maskable index k is F2 minus two k
   function automatic logic [15:0] idx_vec(input int k);
      idx_vec = VEC_EXT - 16'(2 * k);
   endfunction

   // promotion code is valid when implemented and not above F2
   function automatic logic prio_valid(input logic [7:0] p);
      logic [7:0] k;
      k = 8'((PRIO_EXT - p) >> 1);
      // index guard keeps the mask lookup inside its range
      prio_valid = (p <= PRIO_EXT) && (p >= PRIO_LOW_MIN) && !p[0]
                   && (k < 8'(NSRC)) && IMPL_MASK[k[5:0]];
   endfunction

   // R9 low level on the external request pin
   // R25 pin disconnected while enable is clear
   assign ext_level = st_ff.ext_en && !st_ff.ext_s2;
   // R24 level or latched falling edge
   assign ext_req = st_ff.edge_sel ? st_ff.edge_latch : ext_level;

   // R12 peripheral flags gated by their local enables
   // R14 index 0 is external line, index 1 the periodic source, then timers
   // R15 R16 R17 R18 R19 R20 peripheral bit k serves vector F0 minus two k
   always_comb begin
      req = '0;
      req[0] = ext_req;
      for (int k = 0; k < NPERIPH; k++) begin
         req[k+1] = periph_flag_in[k] && periph_en_in[k];
      end
   end
   assign code_ok = IMPL_MASK;
   assign wb_hit = wb_req_in.cyc && wb_req_in.stb && !st_ff.ack;

   // next state: sync, latch, registers, arbitration
   always_comb begin
      logic [7:0] pidx;
      logic [15:0] mvec;
      logic mhit;
      pidx = 8'((PRIO_EXT - st_ff.prio) >> 1);
      mvec = VEC_EXT;
      mhit = 1'b0;
      nxt_st = st_ff;
      nxt_st.ext_s1 = ext_req_n_in;
      nxt_st.ext_s2 = st_ff.ext_s1;
      nxt_st.ext_prev = st_ff.ext_s2;
      nxt_st.nmi_s1 = nonmaskable_ext_line_n_in;
      nxt_st.nmi_s2 = st_ff.nmi_s1;
      nxt_st.ack = wb_hit;
      // R11 edge latch: set on falling edge, cleared on service, set wins
      if (service_in && vector_out == VEC_EXT && st_ff.edge_sel) begin
         nxt_st.edge_latch = 1'b0;
      end
      if (st_ff.edge_sel && st_ff.ext_en && st_ff.ext_prev && !st_ff.ext_s2) begin
         nxt_st.edge_latch = 1'b1;
      end
      if (!st_ff.edge_sel) begin
         nxt_st.edge_latch = 1'b0;
      end
      // register writes and read data
      nxt_st.rdata = '0;
      if (wb_hit) begin
         unique case (wb_req_in.adr)
            OFF_CTRL: begin
               if (wb_req_in.we && wb_req_in.sel[0]) begin
                  nxt_st.edge_sel = wb_req_in.dat[CTRL_EDGE_BIT];
                  nxt_st.ext_en = wb_req_in.dat[CTRL_EN_BIT];
               end
               nxt_st.rdata[CTRL_EDGE_BIT] = st_ff.edge_sel;
               nxt_st.rdata[CTRL_EN_BIT] = st_ff.ext_en;
            end
            OFF_PRIO: begin
               // R8 write accepted only while I is set
               if (wb_req_in.we && wb_req_in.sel[0] && i_mask_in) begin
                  nxt_st.prio = wb_req_in.dat[7:0];
               end
               nxt_st.rdata[7:0] = st_ff.prio;
            end
            OFF_STAT: nxt_st.rdata = {15'h0, st_ff.valid, st_ff.vector};
            default: nxt_st.rdata = '0;
         endcase
      end
      // R6 R14 default order, lowest index first
      for (int k = NSRC - 1; k >= 0; k--) begin
         if (req[k] && code_ok[k]) begin
            mvec = idx_vec(k);
            mhit = 1'b1;
         end
      end
      // R22 invalid code promotes external line, which is already first
      // R7 promoted source still needs its request and I; vector unchanged
      if (prio_valid(st_ff.prio) && req[pidx[5:0]]) begin
         mvec = idx_vec(int'(pidx[5:0]));
      end
      // R5 maskable requests only with I clear
      if (i_mask_in) mhit = 1'b0;
      // R3 R13 fixed non-maskable order above all maskable
      nxt_st.valid = 1'b1;
      if (por_req_in) nxt_st.vector = VEC_RESET;
      else if (clkmon_req_in) nxt_st.vector = VEC_CLKMON;
      else if (wdog_req_in) nxt_st.vector = VEC_WDOG;
      else if (trap_req_in) nxt_st.vector = VEC_TRAP;
      else if (swtrap_req_in) nxt_st.vector = VEC_SWTRAP;
      // R4 R9 level line gated by X
      else if (!st_ff.nmi_s2 && !x_mask_in) nxt_st.vector = VEC_NMI;
      // R26 maskable winner
      else if (mhit) nxt_st.vector = mvec;
      // R10 vanished request at service time falls to trap
      else begin
         nxt_st.vector = VEC_TRAP;
         nxt_st.valid = 1'b0;
      end
   end

   // state register
   // R23 priority select comes out of reset at F2
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_ff <= '{prio: PRIO_RESET, edge_sel: 1'b0, ext_en: 1'b1, ext_s1: 1'b1,
                    ext_s2: 1'b1, ext_prev: 1'b1, edge_latch: 1'b0, nmi_s1: 1'b1,
                    nmi_s2: 1'b1, vector: VEC_RESET, valid: 1'b0, ack: 1'b0,
                    rdata: 32'h0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // R1 R2 outputs from flops, vectors in FF80..FFFE
   assign vector_out = st_ff.vector;
   assign vector_valid_out = st_ff.valid;
   assign wb_ack_out = st_ff.ack;
   assign wb_dat_out = st_ff.rdata;

   // assertions
   logic mhit_cov;
   logic hi_none;
   logic nm_none;
   logic dflt_ok;
   logic [5:0] prom_idx;
   logic prom_hit;
   // helper terms: no higher source pending, default order in force
   assign mhit_cov = vector_valid_out && vector_out < VEC_EXT;
   assign hi_none = !por_req_in && !clkmon_req_in && !wdog_req_in && !trap_req_in
                    && !swtrap_req_in;
   assign nm_none = hi_none && (st_ff.nmi_s2 || x_mask_in);
   assign dflt_ok = nm_none && !i_mask_in && st_ff.prio == PRIO_EXT;
   // promoted index and whether it is requested
   assign prom_idx = 6'((PRIO_EXT - st_ff.prio) >> 1);
   assign prom_hit = prio_valid(st_ff.prio) && req[prom_idx];

   a_vector_top_range: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      vector_out >= VEC_BASE && !vector_out[0]) else $error("vector out of range"); // R1
   a_reset_first: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      por_req_in |=> vector_out == VEC_RESET) else $error("reset not first"); // R3
   a_clkmon_order: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      !por_req_in && clkmon_req_in |=> vector_out == VEC_CLKMON)
      else $error("clock monitor order"); // R13
   a_imask_blocks: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      i_mask_in |=> vector_out >= VEC_NMI || !vector_valid_out)
      else $error("maskable taken with I set"); // R5
   a_prio_locked: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      wb_hit && wb_req_in.we && wb_req_in.adr == OFF_PRIO && !i_mask_in
      |=> $stable(st_ff.prio)) else $error("priority written with I clear"); // R8
   a_nmi_xgate: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      x_mask_in |=> vector_out != VEC_NMI) else $error("nmi with X set"); // R4
   a_edge_clear: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      st_ff.edge_sel && service_in && vector_out == VEC_EXT
      && !(st_ff.ext_prev && !st_ff.ext_s2) |=> !st_ff.edge_latch)
      else $error("edge latch not cleared"); // R11
   a_ext_disc: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      !st_ff.ext_en && !st_ff.edge_latch |-> !ext_req) else $error("pin not disconnected"); // R25
   a_ack_one: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      wb_ack_out |=> !wb_ack_out) else $error("ack held");

   // fixed order of the remaining non-maskable sources
   a_wdog_order: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      !por_req_in && !clkmon_req_in && wdog_req_in |=> vector_out == VEC_WDOG)
      else $error("watchdog order"); // R3
   a_trap_order: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      !por_req_in && !clkmon_req_in && !wdog_req_in && trap_req_in
      |=> vector_out == VEC_TRAP && vector_valid_out) else $error("trap order"); // R3
   a_swtrap_order: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      !por_req_in && !clkmon_req_in && !wdog_req_in && !trap_req_in && swtrap_req_in
      |=> vector_out == VEC_SWTRAP) else $error("soft trap order"); // R13
   a_nmi_taken: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      hi_none && !st_ff.nmi_s2 && !x_mask_in |=> vector_out == VEC_NMI)
      else $error("nmi level not taken"); // R9

   // maskable slots and the empty case
   a_maskable_slot: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      vector_valid_out && vector_out < VEC_NMI |-> vector_out <= VEC_EXT)
      else $error("maskable vector in fixed slot"); // R2
   a_empty_trap: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      nm_none && (i_mask_in || req == '0)
      |=> vector_out == VEC_TRAP && !vector_valid_out) else $error("empty not trap"); // R10
   a_flag_served: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      nm_none && !i_mask_in && req != '0
      |=> vector_valid_out && vector_out <= VEC_EXT) else $error("flag not served"); // R12

   // promotion wins, stays gated, and bad codes fall to the external line
   a_prom_wins: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      nm_none && !i_mask_in && prom_hit |=> vector_out == idx_vec(int'(prom_idx)))
      else $error("promoted source lost"); // R6
   a_prom_gated: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      nm_none && prio_valid(st_ff.prio) && !req[prom_idx]
      |=> vector_out != idx_vec(int'(prom_idx))) else $error("promotion ungated"); // R7
   a_bad_code_ext: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      nm_none && !i_mask_in && !prio_valid(st_ff.prio) && ext_req
      |=> vector_out == VEC_EXT) else $error("bad code not external"); // R22

   // default order: the lowest-index pending request yields its documented vector
   a_periodic_slot: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      dflt_ok && req[1:0] == 2'b10 |=> vector_out == 16'hfff0)
      else $error("periodic vector"); // R14
   a_timer_slot: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      dflt_ok && req[2:0] == 3'b100 |=> vector_out == 16'hffee)
      else $error("timer vector"); // R15
   a_accum_slot: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      dflt_ok && req[11:0] == 12'h800 |=> vector_out == 16'hffdc)
      else $error("accumulator vector"); // R16
   a_spi_slot: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      dflt_ok && req[13:0] == 14'h2000 |=> vector_out == 16'hffd8)
      else $error("spi vector"); // R17
   a_wake_slot: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      dflt_ok && req[17:0] == 18'h20000 |=> vector_out == 16'hffd0)
      else $error("can wake vector"); // R18
   a_accum_b_slot: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      dflt_ok && req[20:0] == 21'h100000 |=> vector_out == 16'hffca)
      else $error("accumulator b vector"); // R19
   a_clkgen_slot: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      dflt_ok && req[24:0] == 25'h1000000 |=> vector_out == 16'hffc2)
      else $error("clock generator vector"); // R20

   // register writes and the bus answer
   a_prio_write: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      wb_hit && wb_req_in.we && wb_req_in.sel[0] && wb_req_in.adr == OFF_PRIO && i_mask_in
      |=> st_ff.prio == $past(wb_req_in.dat[7:0])) else $error("priority write lost"); // R8
   a_prio_idle: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      !wb_hit |=> $stable(st_ff.prio)) else $error("priority changed idle"); // R8
   a_ctrl_write: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      wb_hit && wb_req_in.we && wb_req_in.sel[0] && wb_req_in.adr == OFF_CTRL
      |=> st_ff.edge_sel == $past(wb_req_in.dat[CTRL_EDGE_BIT])
      && st_ff.ext_en == $past(wb_req_in.dat[CTRL_EN_BIT]))
      else $error("control write lost"); // R24
   a_ack_answer: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      wb_hit |=> wb_ack_out) else $error("ack missing");
   a_dat_idle: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      !wb_hit |=> wb_dat_out == 32'h0) else $error("read data outside ack");

   // external line recognition modes
   a_edge_set: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      st_ff.edge_sel && st_ff.ext_en && st_ff.ext_prev && !st_ff.ext_s2
      |=> st_ff.edge_latch) else $error("edge not latched"); // R11
   a_level_mode: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      st_ff.ext_en && !st_ff.edge_sel |-> ext_req == !st_ff.ext_s2)
      else $error("level mode wrong"); // R24
   a_edge_off: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      !st_ff.edge_sel |=> !st_ff.edge_latch) else $error("latch in level mode"); // R24

   // main scenarios
   c_ext_served: cover property (@(posedge ref_clk_in) vector_out == VEC_EXT);
   c_promoted: cover property (@(posedge ref_clk_in) st_ff.prio != PRIO_RESET && mhit_cov);
   c_nmi: cover property (@(posedge ref_clk_in) vector_out == VEC_NMI);
   c_edge_latched: cover property (@(posedge ref_clk_in) st_ff.edge_latch);
   c_trap_empty: cover property (@(posedge ref_clk_in) arst_n_in && !vector_valid_out);
endmodule

// ==== epv_periph_model.sv ====
// model of peripheral interrupt sources holding request flags
`timescale 1ns/1ps
module epv_periph_model (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic [23:0] raise_in,
   input wire logic [15:0] vector_in,
   input wire logic service_in,
   output logic [23:0] flag_out
);
   logic [23:0] flag_ff;
   assign flag_out = flag_ff;
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         flag_ff <= 24'h000000;
      end else begin
         for (int k = 0; k < 24; k++) begin
            if (raise_in[k]) begin
               flag_ff[k] <= 1'b1;
            end else if (service_in && vector_in == 16'hfff0 - 16'(2 * k)) begin
               flag_ff[k] <= 1'b0;
            end
         end
      end
   end
endmodule

// ==== exception_priority_vectoring_bench.sv ====
// testbench for the exception arbiter
`timescale 1ns/1ps
module exception_priority_vectoring_bench;
   import epv_pkg::*;
   logic clk = 0, arst_n = 0, nmi_n = 1, ext_n = 1, xm = 1, im = 1, srv = 0, ack, valid;
   logic [4:0] nm = 5'h00;
   logic [23:0] raise = 24'h000000, en = 24'hffffff, flag;
   logic [31:0] dat, rdv;
   logic [15:0] vec;
   epv_wb_req_t req = '0;
   int failures = 0, n_checks = 0;
   epv_arbiter #(.NPERIPH(24)) dut (.ref_clk_in(clk), .arst_n_in(arst_n), .wb_req_in(req),
      .wb_dat_out(dat), .wb_ack_out(ack), .por_req_in(nm[4]), .clkmon_req_in(nm[3]),
      .wdog_req_in(nm[2]), .trap_req_in(nm[1]), .swtrap_req_in(nm[0]),
      .nonmaskable_ext_line_n_in(nmi_n), .ext_req_n_in(ext_n), .x_mask_in(xm),
      .i_mask_in(im), .periph_flag_in(flag), .periph_en_in(en), .service_in(srv),
      .vector_out(vec), .vector_valid_out(valid));
   epv_periph_model model (.ref_clk_in(clk), .arst_n_in(arst_n), .raise_in(raise),
      .vector_in(vec), .service_in(srv), .flag_out(flag));
   // clock at 100 ns period
   initial begin
      forever #50 clk = ~clk;
   end
   task end_of_test;
      if (failures == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   // classic wishbone single cycle, held until ack
   task wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
      int t;
      t = 0;
      @(posedge clk);
      req <= '{1'b1, 1'b1, we, adr, 4'h1, wd};
      do begin
         @(posedge clk);
         t++;
      end while (ack !== 1'b1 && t < 50);
      if (t >= 50) failures++;
      rdv = dat;
      req <= '0;
      @(posedge clk);
   endtask
   task rd(input logic [3:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0);
      chk("read data", exp, rdv);
   endtask
   // let inputs pass the sync stages, then compare
   task vchk(input logic [15:0] v, input logic ok);
      repeat (6) @(posedge clk);
      #1;
      chk("vector", {16'h0, v}, {16'h0, vec});
      chk("valid", {31'h0, ok}, {31'h0, valid});
   endtask
   task pulse_service;
      @(posedge clk) srv <= 1'b1;
      @(posedge clk) srv <= 1'b0;
   endtask
   initial begin
      #3000000;
      failures++;
      end_of_test();
   end
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      vchk(16'hfff8, 1'b0);
      rd(OFF_CTRL, {24'h0, CTRL_RESET});
      rd(OFF_PRIO, 32'h000000f2);
      rd(4'hc, 32'h0);
      @(posedge clk) nm <= 5'h1f;
      nmi_n <= 1'b0;
      xm <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         vchk(16'hfffe - 16'(2 * i), 1'b1);
         @(posedge clk) nm <= nm >> 1;
      end
      xm <= 1'b1;
      vchk(16'hfff8, 1'b0);
      @(posedge clk) nmi_n <= 1'b1;
      raise <= 24'h000021;
      @(posedge clk) raise <= 24'h0;
      vchk(16'hfff8, 1'b0);
      @(posedge clk) im <= 1'b0;
      vchk(16'hfff0, 1'b1);
      @(posedge clk) en <= 24'hfffffe;
      vchk(16'hffe6, 1'b1);
      @(posedge clk) en <= 24'hffffff;
      im <= 1'b1;
      wb(1'b1, OFF_PRIO, 32'he6);
      @(posedge clk) im <= 1'b0;
      vchk(16'hffe6, 1'b1);
      wb(1'b1, OFF_PRIO, 32'hf0);
      rd(OFF_PRIO, 32'h000000e6);
      @(posedge clk) ext_n <= 1'b0;
      vchk(16'hffe6, 1'b1);
      @(posedge clk) im <= 1'b1;
      wb(1'b1, OFF_PRIO, 32'hf4);
      @(posedge clk) im <= 1'b0;
      vchk(16'hfff2, 1'b1);
      @(posedge clk) ext_n <= 1'b1;
      vchk(16'hfff0, 1'b1);
      pulse_service();
      vchk(16'hffe6, 1'b1);
      pulse_service();
      vchk(16'hfff8, 1'b0);
      wb(1'b1, OFF_CTRL, 32'hc0);
      @(posedge clk) ext_n <= 1'b0;
      repeat (2) @(posedge clk);
      ext_n <= 1'b1;
      vchk(16'hfff2, 1'b1);
      pulse_service();
      vchk(16'hfff8, 1'b0);
      wb(1'b1, OFF_CTRL, 32'h00);
      @(posedge clk) ext_n <= 1'b0;
      vchk(16'hfff8, 1'b0);
      rd(OFF_STAT, 32'h0000fff8);
      end_of_test();
   end
endmodule
